// ---- src/mioc_consts.svh ----
// constants of the motion i/o command handler: offsets, codes, fields
`ifndef MIOC_CONSTS_SVH
`define MIOC_CONSTS_SVH

// apb register byte offsets
`define MIOC_OFS_CMD_HDR   8'h00
`define MIOC_OFS_CMD_VAL   8'h04
`define MIOC_OFS_CMD_SUM   8'h08
`define MIOC_OFS_CTRL      8'h0C
`define MIOC_OFS_STATUS    8'h10
`define MIOC_OFS_RPL_HDR   8'h14
`define MIOC_OFS_RPL_VAL   8'h18
`define MIOC_OFS_RPL_SUM   8'h1C
`define MIOC_OFS_ACCU      8'h20
`define MIOC_OFS_IO_STATE  8'h24

// control and status bit positions
`define MIOC_CTRL_GO_BIT      0
`define MIOC_CTRL_STANDALONE  1
`define MIOC_STAT_BUSY_BIT    0
`define MIOC_STAT_READY_BIT   1

// frame addresses (values arbitrary)
`define MIOC_MODULE_ADDR  8'h01
`define MIOC_HOST_ADDR    8'h02

// instruction codes
`define MIOC_OP_RESTORE   8'h0C
`define MIOC_OP_REFSRCH   8'h0D
`define MIOC_OP_SETOUT    8'h0E
`define MIOC_OP_GETIO     8'h0F

// reply status codes
`define MIOC_ST_OK        8'h64
`define MIOC_ST_BAD_SUM   8'h01
`define MIOC_ST_BAD_CMD   8'h02
`define MIOC_ST_BAD_TYPE  8'h03
`define MIOC_ST_BAD_VAL   8'h04

// banks, ports, search sub-commands
`define MIOC_BANK_DIN     8'h00
`define MIOC_BANK_AIN     8'h01
`define MIOC_BANK_USER    8'h02
`define MIOC_PORT_ALL     8'hFF
`define MIOC_PORT_LAST    8'h03
`define MIOC_RFS_START    8'h00
`define MIOC_RFS_STOP     8'h01
`define MIOC_RFS_STATUS   8'h02
`define MIOC_AXIS_LAST    8'h02
`define MIOC_VAL_FROM_ACC 32'hFFFFFFFF
`define MIOC_USER_LAST    8'hFF

`endif

// ---- src/mioc_pkg.sv ----
// types of the motion i/o command handler
package mioc_pkg;
  typedef enum logic [4:0] {
    ST_BOOT  = 5'b00001,
    ST_SWEEP = 5'b00010,
    ST_IDLE  = 5'b00100,
    ST_EXEC  = 5'b01000,
    ST_NVM   = 5'b10000
  } mioc_state_t;
  typedef logic [31:0] mioc_word_t;
  typedef logic [7:0]  mioc_byte_t;
  typedef logic [3:0]  mioc_gpio_t;
  typedef logic [2:0]  mioc_axis_t;
endpackage

// ---- src/mioc_handler.sv ----
// motion i/o command handler: apb-fed frame decoder for restore, search, output and input commands
`timescale 1ns/10ps
`include "mioc_consts.svh"

// Functional notes
// - code 12 reloads the user variable picked by type and bank; value ignored
// - code 13 on a motor: type 0 starts, 1 stops, 2 queries reference search
// - search query returns 0 when idle, nonzero while search runs
// - code 14 drives the selected output to value 0 or 1
// - four settable outputs, ports 0 to 3, in bank 2
// - output port 255 sets all outputs at once from value bits
// - output value -1 means take the value from the accumulator
// - code 15 reads the line picked by port and bank; banks 0, 1, 2 valid
// - digital reads give 0 or 1; analog reads give 16-bit unsigned result
// - in standalone mode the input read lands in the accumulator
// - in direct mode the input read of ports 0 to 3 goes only to the reply value
// - bank 0 gives the digital levels of inputs 0 to 3
// - bank 1 gives the analog values of inputs 0 to 3
// - each input readable both as digital level and analog value
// - port 255 in bank 0 captures all inputs as a bit vector into accumulator
// - bank 2 reads return the driven state of each output
// - after power up all user variables reload unless disabled
// - bank 2 selects the user variables for restore
module mioc_handler (
  input  wire logic                 pclk,              // apb clock
  input  wire logic                 presetn,           // async reset, low active
  input  wire logic [11:0]          paddr,             // apb byte address
  input  wire logic                 psel,              // apb select
  input  wire logic                 penable,           // apb access phase
  input  wire logic                 pwrite,            // apb direction
  input  wire mioc_pkg::mioc_word_t pwdata,            // apb write data
  output mioc_pkg::mioc_word_t      prdata,            // apb read data
  output logic                      pready,            // apb ready
  output logic                      pslverr,           // apb error
  input  wire mioc_pkg::mioc_gpio_t gp_input,          // digital levels of inputs
  input  wire logic [63:0]          adc_value,         // four 16-bit conversions
  output mioc_pkg::mioc_gpio_t      gp_output,         // driven outputs
  output mioc_pkg::mioc_axis_t      rfs_start,         // per-axis search start pulse
  output mioc_pkg::mioc_axis_t      rfs_stop,          // per-axis search stop pulse
  input  wire mioc_pkg::mioc_axis_t rfs_active,        // per-axis search running
  output logic                      nvm_restore_req,   // reload request, held until ack
  output mioc_pkg::mioc_byte_t      nvm_restore_index, // user variable index
  input  wire logic                 nvm_restore_ack,   // reload done
  input  wire logic                 auto_restore_en    // reload all after reset
);
  import mioc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  mioc_state_t state_q, state_d;
  mioc_word_t  cmd_hdr_q, cmd_hdr_d;
  mioc_word_t  cmd_val_q, cmd_val_d;
  mioc_byte_t  cmd_sum_q, cmd_sum_d;
  logic        standalone_q, standalone_d;
  logic        ready_q, ready_d;
  mioc_byte_t  rpl_status_q, rpl_status_d;
  mioc_byte_t  rpl_op_q, rpl_op_d;
  mioc_word_t  rpl_val_q, rpl_val_d;
  mioc_byte_t  rpl_sum_q, rpl_sum_d;
  mioc_word_t  acc_q, acc_d;
  mioc_gpio_t  out_q, out_d;
  mioc_axis_t  start_q, start_d;
  mioc_axis_t  stop_q, stop_d;
  logic        req_q, req_d;
  mioc_byte_t  idx_q, idx_d;

  logic [15:0] adc_ch [4];
  logic        wr_en;
  logic        rd_en;
  logic        busy;
  logic        ready_clr;
  mioc_byte_t  f_target;
  mioc_byte_t  f_op;
  mioc_byte_t  f_type;
  mioc_byte_t  f_bank;
  mioc_byte_t  f_sum;
  logic        port_ok;
  logic        axis_ok;
  mioc_word_t  set_val;

  function automatic mioc_byte_t sum4(input mioc_word_t w);
    sum4 = mioc_byte_t'(w[31:24] + w[23:16] + w[15:8] + w[7:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // frame fields and input unpacking

  for (genvar g = 0; g < 4; g++)
  begin : g_adc
    assign adc_ch[g] = adc_value[g*16 +: 16];
  end

  // field order of the command frame
  assign f_target = cmd_hdr_q[31:24];
  assign f_op     = cmd_hdr_q[23:16];
  assign f_type   = cmd_hdr_q[15:8];
  assign f_bank   = cmd_hdr_q[7:0];
  assign f_sum    = mioc_byte_t'(sum4(cmd_hdr_q) + sum4(cmd_val_q));
  assign port_ok  = (f_type <= `MIOC_PORT_LAST);
  assign axis_ok  = (f_bank <= `MIOC_AXIS_LAST);
  assign set_val  = (cmd_val_q == `MIOC_VAL_FROM_ACC) ? acc_q : cmd_val_q;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  // software clear of the reply flag; a reply set in the same cycle wins
  assign ready_clr = wr_en && (paddr == {4'h0, `MIOC_OFS_STATUS}) && pwdata[`MIOC_STAT_READY_BIT];
  assign busy    = (state_q != ST_IDLE);
  assign pready  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // apb read path

  always_comb
  begin
    prdata  = '0;
    pslverr = 1'b0;
    case (paddr[7:0])
      `MIOC_OFS_CMD_HDR:  prdata = cmd_hdr_q;
      `MIOC_OFS_CMD_VAL:  prdata = cmd_val_q;
      `MIOC_OFS_CMD_SUM:  prdata = {24'h000000, cmd_sum_q};
      `MIOC_OFS_CTRL:     prdata[`MIOC_CTRL_STANDALONE] = standalone_q;
      `MIOC_OFS_STATUS:
      begin
        prdata[`MIOC_STAT_BUSY_BIT]  = busy;
        prdata[`MIOC_STAT_READY_BIT] = ready_q;
      end
      `MIOC_OFS_RPL_HDR:  prdata = {`MIOC_HOST_ADDR, `MIOC_MODULE_ADDR, rpl_status_q, rpl_op_q};
      `MIOC_OFS_RPL_VAL:  prdata = rpl_val_q;
      `MIOC_OFS_RPL_SUM:  prdata = {24'h000000, rpl_sum_q};
      `MIOC_OFS_ACCU:     prdata = acc_q;
      `MIOC_OFS_IO_STATE: prdata = {24'h000000, gp_input, out_q};
      default:            pslverr = psel && penable;
    endcase
    if (paddr[11:8] != 4'h0)
    begin
      pslverr = psel && penable;
      prdata  = '0;
    end
    if (!rd_en)
    begin
      prdata = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: register writes, power-up reload, command execution

  always_comb
  begin
    state_d      = state_q;
    cmd_hdr_d    = cmd_hdr_q;
    cmd_val_d    = cmd_val_q;
    cmd_sum_d    = cmd_sum_q;
    standalone_d = standalone_q;
    ready_d      = ready_q;
    rpl_status_d = rpl_status_q;
    rpl_op_d     = rpl_op_q;
    rpl_val_d    = rpl_val_q;
    acc_d        = acc_q;
    out_d        = out_q;
    start_d      = '0;
    stop_d       = '0;
    req_d        = req_q;
    idx_d        = idx_q;

    if (wr_en && (paddr[11:8] == 4'h0))
    begin
      case (paddr[7:0])
        `MIOC_OFS_CMD_HDR: if (!busy) cmd_hdr_d = pwdata;
        `MIOC_OFS_CMD_VAL: if (!busy) cmd_val_d = pwdata;
        `MIOC_OFS_CMD_SUM: if (!busy) cmd_sum_d = pwdata[7:0];
        `MIOC_OFS_CTRL:    standalone_d = pwdata[`MIOC_CTRL_STANDALONE];
        `MIOC_OFS_STATUS:  if (pwdata[`MIOC_STAT_READY_BIT]) ready_d = 1'b0;
        `MIOC_OFS_ACCU:    acc_d = pwdata;
        default:           ;
      endcase
    end

    case (state_q)
      ST_BOOT:
      begin
        idx_d = '0;
        req_d = auto_restore_en;
        state_d = auto_restore_en ? ST_SWEEP : ST_IDLE;
      end
      ST_SWEEP:
      begin
        if (nvm_restore_ack)
        begin
          if (idx_q == `MIOC_USER_LAST)
          begin
            req_d   = 1'b0;
            state_d = ST_IDLE;
          end
          else
          begin
            idx_d = mioc_byte_t'(idx_q + 8'h01);
          end
        end
      end
      ST_IDLE:
      begin
        if (wr_en && (paddr == {4'h0, `MIOC_OFS_CTRL}) && pwdata[`MIOC_CTRL_GO_BIT])
        begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        state_d      = ST_IDLE;
        rpl_op_d     = f_op;
        rpl_status_d = `MIOC_ST_OK;
        rpl_val_d    = '0;
        ready_d      = 1'b1;
        if (f_target != `MIOC_MODULE_ADDR)
        begin
          ready_d = ready_q && !ready_clr;
        end
        else if (f_sum != cmd_sum_q)
        begin
          rpl_status_d = `MIOC_ST_BAD_SUM;
        end
        else
        begin
          case (f_op)
            `MIOC_OP_RESTORE:
            begin
              if (f_bank == `MIOC_BANK_USER)
              begin
                idx_d   = f_type;
                req_d   = 1'b1;
                ready_d = ready_q && !ready_clr;
                state_d = ST_NVM;
              end
              else
              begin
                rpl_status_d = `MIOC_ST_BAD_VAL;
              end
            end
            `MIOC_OP_REFSRCH:
            begin
              if (!axis_ok)
              begin
                rpl_status_d = `MIOC_ST_BAD_VAL;
              end
              else if (f_type == `MIOC_RFS_START)
              begin
                start_d[f_bank[1:0]] = 1'b1;
              end
              else if (f_type == `MIOC_RFS_STOP)
              begin
                stop_d[f_bank[1:0]] = 1'b1;
              end
              else if (f_type == `MIOC_RFS_STATUS)
              begin
                rpl_val_d = {31'h00000000, rfs_active[f_bank[1:0]]};
              end
              else
              begin
                rpl_status_d = `MIOC_ST_BAD_TYPE;
              end
            end
            `MIOC_OP_SETOUT:
            begin
              if (f_bank != `MIOC_BANK_USER)
              begin
                rpl_status_d = `MIOC_ST_BAD_VAL;
              end
              else if (f_type == `MIOC_PORT_ALL)
              begin
                out_d = set_val[3:0];
              end
              else if (port_ok)
              begin
                out_d[f_type[1:0]] = set_val[0];
              end
              else
              begin
                rpl_status_d = `MIOC_ST_BAD_TYPE;
              end
            end
            `MIOC_OP_GETIO:
            begin
              if ((f_bank == `MIOC_BANK_DIN) && (f_type == `MIOC_PORT_ALL))
              begin
                rpl_val_d = {28'h0000000, gp_input};
                acc_d     = {28'h0000000, gp_input};
              end
              else if (!port_ok)
              begin
                rpl_status_d = `MIOC_ST_BAD_TYPE;
              end
              else
              begin
                case (f_bank)
                  `MIOC_BANK_DIN:  rpl_val_d = {31'h00000000, gp_input[f_type[1:0]]};
                  `MIOC_BANK_AIN:  rpl_val_d = {16'h0000, adc_ch[f_type[1:0]]};
                  `MIOC_BANK_USER: rpl_val_d = {31'h00000000, out_q[f_type[1:0]]};
                  default:         rpl_status_d = `MIOC_ST_BAD_VAL;
                endcase
                if (standalone_q && (rpl_status_d == `MIOC_ST_OK))
                begin
                  acc_d = rpl_val_d;
                end
                // direct mode leaves the accumulator alone
              end
            end
            default: rpl_status_d = `MIOC_ST_BAD_CMD;
          endcase
        end
      end
      ST_NVM:
      begin
        if (nvm_restore_ack)
        begin
          req_d   = 1'b0;
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // reply checksum over the eight leading bytes
  assign rpl_sum_d = mioc_byte_t'(`MIOC_HOST_ADDR + `MIOC_MODULE_ADDR + rpl_status_d + rpl_op_d
                                  + sum4(rpl_val_d));

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q      <= ST_BOOT;
      cmd_hdr_q    <= '0;
      cmd_val_q    <= '0;
      cmd_sum_q    <= '0;
      standalone_q <= 1'b0;
      ready_q      <= 1'b0;
      rpl_status_q <= '0;
      rpl_op_q     <= '0;
      rpl_val_q    <= '0;
      rpl_sum_q    <= '0;
      acc_q        <= '0;
      out_q        <= '0;
      start_q      <= '0;
      stop_q       <= '0;
      req_q        <= 1'b0;
      idx_q        <= '0;
    end
    else
    begin
      state_q      <= state_d;
      cmd_hdr_q    <= cmd_hdr_d;
      cmd_val_q    <= cmd_val_d;
      cmd_sum_q    <= cmd_sum_d;
      standalone_q <= standalone_d;
      ready_q      <= ready_d;
      rpl_status_q <= rpl_status_d;
      rpl_op_q     <= rpl_op_d;
      rpl_val_q    <= rpl_val_d;
      rpl_sum_q    <= rpl_sum_d;
      acc_q        <= acc_d;
      out_q        <= out_d;
      start_q      <= start_d;
      stop_q       <= stop_d;
      req_q        <= req_d;
      idx_q        <= idx_d;
    end
  end

  assign gp_output         = out_q;
  assign rfs_start         = start_q;
  assign rfs_stop          = stop_q;
  assign nvm_restore_req   = req_q;
  assign nvm_restore_index = idx_q;

endmodule

// ---- test/mioc_handler_assertions.sv ----
// port checker of the motion i/o command handler
`timescale 1ns/10ps
`include "mioc_consts.svh"
module mioc_chk (
  input wire logic                 pclk,              // clock
  input wire logic                 presetn,           // reset
  input wire logic [11:0]          paddr,             // address
  input wire logic                 psel,              // select
  input wire logic                 penable,           // access
  input wire logic                 pwrite,            // direction
  input wire mioc_pkg::mioc_word_t pwdata,            // write data
  input wire mioc_pkg::mioc_word_t prdata,            // read data
  input wire logic                 pslverr,           // error
  input wire mioc_pkg::mioc_gpio_t gp_output,         // outputs
  input wire mioc_pkg::mioc_axis_t rfs_start,         // starts
  input wire mioc_pkg::mioc_axis_t rfs_stop,          // stops
  input wire logic                 nvm_restore_req,   // reload
  input wire mioc_pkg::mioc_byte_t nvm_restore_index, // index
  input wire logic                 nvm_restore_ack,   // done
  input wire logic                 auto_restore_en    // boot reload
);
  import mioc_pkg::*;
  logic [1:0] boot_q;
  logic [1:0] boot_d;
  logic       go;
  assign go = psel && penable && pwrite && paddr == {4'h0, `MIOC_OFS_CTRL} && pwdata[`MIOC_CTRL_GO_BIT];
  always_comb boot_d = (boot_q == 2'h3) ? boot_q : boot_q + 2'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      boot_q <= 2'h0;
    else
      boot_q <= boot_d;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  a_err_unmapped: assert property (psel && penable && paddr > 12'h024 |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (psel && penable && paddr <= 12'h024 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped access");
  a_rd_idle_zero: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read");
  a_boot_sweep: assert property (boot_q == 2'h0 && auto_restore_en |->
    ##[1:2] (nvm_restore_req && nvm_restore_index == 8'h00))
    else $error("boot reload did not start at index 0");
  a_req_hold: assert property (nvm_restore_req && !nvm_restore_ack |=>
    nvm_restore_req && $stable(nvm_restore_index))
    else $error("reload request dropped early");
  a_pulse_short: assert property ((rfs_start | rfs_stop) != 3'h0 |=> (rfs_start | rfs_stop) == 3'h0)
    else $error("search pulse too long");
  a_pulse_one: assert property ($onehot0(rfs_start | rfs_stop))
    else $error("several search pulses");
  a_pulse_cause: assert property ((rfs_start | rfs_stop) != 3'h0 |-> $past(go, 2) || $past(go, 3))
    else $error("search pulse without command");
  a_out_cause: assert property (!$stable(gp_output) |-> $past(go, 2))
    else $error("outputs changed without command");
endmodule
bind mioc_handler mioc_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pslverr, .gp_output, .rfs_start, .rfs_stop, .nvm_restore_req, .nvm_restore_index, .nvm_restore_ack,
  .auto_restore_en);

// ---- test/mioc_partner.sv ----
// model of the search engines and variable store beside the handler
`timescale 1ns/10ps
module mioc_partner (
  input  wire logic                 pclk,            // clock
  input  wire logic                 presetn,         // reset
  input  wire mioc_pkg::mioc_axis_t rfs_start,       // starts
  input  wire mioc_pkg::mioc_axis_t rfs_stop,        // stops
  input  wire logic                 nvm_restore_req, // reload
  input  wire logic                 slow,            // late answers
  output mioc_pkg::mioc_axis_t      rfs_active,      // searching
  output logic                      nvm_restore_ack, // done
  output int                        n_ack            // reloads done
);
  import mioc_pkg::*;
  logic [1:0] wait_q;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rfs_active <= '0;
      nvm_restore_ack <= 1'b0;
      wait_q <= 2'h0;
      n_ack <= 0;
    end
    else
    begin
      rfs_active <= (rfs_active | rfs_start) & ~rfs_stop;
      nvm_restore_ack <= 1'b0;
      if (nvm_restore_req && !nvm_restore_ack)
      begin
        if (wait_q == (slow ? 2'h3 : 2'h0))
        begin
          nvm_restore_ack <= 1'b1;
          wait_q <= 2'h0;
          n_ack <= n_ack + 1;
        end
        else
          wait_q <= wait_q + 2'h1;
      end
    end
endmodule

// ---- test/mioc_handler_bench.sv ----
// self-checking bench of the motion i/o command handler
`timescale 1ns/10ps
`include "mioc_consts.svh"
module mioc_handler_bench;
  import mioc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = '0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  mioc_word_t  pwdata = '0;
  mioc_word_t  prdata;
  logic        pready;
  logic        pslverr;
  mioc_gpio_t  gp_input = '0;
  logic [63:0] adc_value = '0;
  mioc_gpio_t  gp_output;
  mioc_axis_t  rfs_start;
  mioc_axis_t  rfs_stop;
  mioc_axis_t  rfs_active;
  logic        nvm_restore_req;
  mioc_byte_t  nvm_restore_index;
  logic        nvm_restore_ack;
  logic        auto_restore_en = 1'b1;
  logic        slow = 1'b0;
  int          n_ack;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  mioc_word_t  exp_q[$];
  mioc_word_t  msk_q[$];
  mioc_word_t  r;
  mioc_word_t  x;
  mioc_word_t  e;
  mioc_word_t  m;
  mioc_handler u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .gp_input, .adc_value, .gp_output, .rfs_start, .rfs_stop, .rfs_active, .nvm_restore_req,
    .nvm_restore_index, .nvm_restore_ack, .auto_restore_en);
  mioc_partner u_far (.pclk, .presetn, .rfs_start, .rfs_stop, .nvm_restore_req, .slow, .rfs_active,
    .nvm_restore_ack, .n_ack);
  initial
    forever #2.5 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic check(input mioc_word_t seen, input mioc_word_t exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one transfer; reads leave their expectation for the monitor
  task automatic apb(input logic w, input mioc_byte_t a, input mioc_word_t d, input mioc_word_t ev,
                     input mioc_word_t em, output mioc_word_t rv);
    if (!w)
    begin
      exp_q.push_back(ev);
      msk_q.push_back(em);
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdq(input mioc_byte_t a, input mioc_word_t ev);
    apb(1'b0, a, '0, ev, '1, r);
  endtask
  // waits for a status bit; only the watchdog ends a hang
  task automatic poll(input int b, input logic v);
    do apb(1'b0, `MIOC_OFS_STATUS, '0, '0, '0, r); while (r[b] !== v);
  endtask
  task automatic cmd(input mioc_byte_t op, input mioc_byte_t ty, input mioc_byte_t bk, input mioc_word_t v,
                     input mioc_byte_t st, input mioc_word_t ev, input mioc_word_t em, input logic sa,
                     input mioc_byte_t skew);
    mioc_byte_t s;
    s = `MIOC_MODULE_ADDR + op + ty + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0] + skew;
    apb(1'b1, `MIOC_OFS_CMD_HDR, {`MIOC_MODULE_ADDR, op, ty, bk}, '0, '0, r);
    apb(1'b1, `MIOC_OFS_CMD_VAL, v, '0, '0, r);
    apb(1'b1, `MIOC_OFS_CMD_SUM, {24'h0, s}, '0, '0, r);
    apb(1'b1, `MIOC_OFS_CTRL, {30'h0, sa, 1'b1}, '0, '0, r);
    poll(`MIOC_STAT_READY_BIT, 1'b1);
    rdq(`MIOC_OFS_RPL_HDR, {`MIOC_HOST_ADDR, `MIOC_MODULE_ADDR, st, op});
    apb(1'b0, `MIOC_OFS_RPL_VAL, '0, ev, em, r);
    s = `MIOC_HOST_ADDR + `MIOC_MODULE_ADDR + st + op + ev[31:24] + ev[23:16] + ev[15:8] + ev[7:0];
    apb(1'b0, `MIOC_OFS_RPL_SUM, '0, {24'h0, s}, {24'h0, {8{&em}}}, r);
    apb(1'b1, `MIOC_OFS_STATUS, 32'h2, '0, '0, r);
  endtask
  task automatic q(input mioc_byte_t op, input mioc_byte_t ty, input mioc_byte_t bk, input mioc_word_t v,
                   input mioc_word_t ev, input mioc_word_t em);
    cmd(op, ty, bk, v, `MIOC_ST_OK, ev, em, 1'b0, 8'h00);
  endtask
  // compares each finished read that has a nonzero mask with the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m !== 32'h0)
        check(prdata & m, e);
    end
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(50424));
    gp_input <= mioc_gpio_t'($urandom);
    adc_value <= {$urandom, $urandom};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    poll(`MIOC_STAT_BUSY_BIT, 1'b0);
    check(n_ack, 256);
    slow <= 1'b1;
    q(`MIOC_OP_RESTORE, 8'h2A, `MIOC_BANK_USER, 32'h0, 0, 0);
    check(n_ack, 257);
    check(nvm_restore_index, 32'h0000002A);
    cmd(`MIOC_OP_RESTORE, 8'h2A, 8'h00, 0, `MIOC_ST_BAD_VAL, 0, 0, 1'b0, 8'h00);
    for (int a = 0; a < 3; a++)
    begin
      q(`MIOC_OP_REFSRCH, `MIOC_RFS_START, 8'(a), 0, 0, 0);
      q(`MIOC_OP_REFSRCH, `MIOC_RFS_STATUS, 8'(a), 0, 1, '1);
      q(`MIOC_OP_REFSRCH, `MIOC_RFS_STOP, 8'(a), 0, 0, 0);
      q(`MIOC_OP_REFSRCH, `MIOC_RFS_STATUS, 8'(a), 0, 0, '1);
    end
    for (int p = 0; p < 4; p++)
    begin
      q(`MIOC_OP_SETOUT, 8'(p), `MIOC_BANK_USER, 1, 0, 0);
      q(`MIOC_OP_GETIO, 8'(p), `MIOC_BANK_USER, 0, 1, '1);
      q(`MIOC_OP_GETIO, 8'(p), `MIOC_BANK_DIN, 0, gp_input[p], '1);
      q(`MIOC_OP_GETIO, 8'(p), `MIOC_BANK_AIN, 0, adc_value[16*p+:16], '1);
    end
    rdq(`MIOC_OFS_IO_STATE, {24'h0, gp_input, 4'hF});
    x = $urandom;
    q(`MIOC_OP_SETOUT, `MIOC_PORT_ALL, `MIOC_BANK_USER, {28'h0, x[3:0]}, 0, 0);
    rdq(`MIOC_OFS_IO_STATE, {24'h0, gp_input, x[3:0]});
    check(gp_output, {28'h0, x[3:0]});
    apb(1'b1, `MIOC_OFS_ACCU, 32'h1234ABCD, '0, '0, r);
    q(`MIOC_OP_GETIO, 8'h01, `MIOC_BANK_AIN, 0, adc_value[31:16], '1);
    rdq(`MIOC_OFS_ACCU, 32'h1234ABCD);
    cmd(`MIOC_OP_GETIO, 8'h02, `MIOC_BANK_AIN, 0, `MIOC_ST_OK, 0, 0, 1'b1, 8'h00);
    rdq(`MIOC_OFS_ACCU, {16'h0, adc_value[47:32]});
    q(`MIOC_OP_GETIO, `MIOC_PORT_ALL, `MIOC_BANK_DIN, 0, {28'h0, gp_input}, '1);
    rdq(`MIOC_OFS_ACCU, {28'h0, gp_input});
    q(`MIOC_OP_SETOUT, `MIOC_PORT_ALL, `MIOC_BANK_USER, `MIOC_VAL_FROM_ACC, 0, 0);
    rdq(`MIOC_OFS_IO_STATE, {24'h0, gp_input, gp_input});
    cmd(8'h10, 8'h00, 8'h00, 0, `MIOC_ST_BAD_CMD, 0, 0, 1'b0, 8'h00);
    cmd(`MIOC_OP_REFSRCH, 8'h03, 8'h00, 0, `MIOC_ST_BAD_TYPE, 0, 0, 1'b0, 8'h00);
    cmd(`MIOC_OP_REFSRCH, `MIOC_RFS_START, 8'h03, 0, `MIOC_ST_BAD_VAL, 0, 0, 1'b0, 8'h00);
    cmd(`MIOC_OP_SETOUT, 8'h04, `MIOC_BANK_USER, 1, `MIOC_ST_BAD_TYPE, 0, 0, 1'b0, 8'h00);
    cmd(`MIOC_OP_SETOUT, 8'h00, 8'h00, 1, `MIOC_ST_BAD_VAL, 0, 0, 1'b0, 8'h00);
    cmd(`MIOC_OP_GETIO, 8'h00, 8'h03, 0, `MIOC_ST_BAD_VAL, 0, 0, 1'b0, 8'h00);
    rdq(`MIOC_OFS_IO_STATE, {24'h0, gp_input, gp_input});
    cmd(`MIOC_OP_GETIO, 8'h00, `MIOC_BANK_DIN, 0, `MIOC_ST_BAD_SUM, 0, 0, 1'b0, 8'h01);
    rdq(8'h40, 32'h0);
    report_and_stop();
  end
endmodule
